//--- design/rsa_defines.svh
`ifndef RSA_DEFINES_SVH
`define RSA_DEFINES_SVH

// ****************************************************************
// Register offsets on the plain register port.
// ****************************************************************
`define RSA_ADDR_CTRL       8'h00
`define RSA_ADDR_REMOTE     8'h04
`define RSA_ADDR_PB         8'h08
`define RSA_ADDR_STATUS     8'h0c

// ****************************************************************
// Field positions.
// ****************************************************************
`define RSA_CTRL_TERM_EN    0
`define RSA_CTRL_SEL_LSB    4
`define RSA_CTRL_SEL_MSB    7
`define RSA_REM_RUN         0
`define RSA_REM_STOP        1
`define RSA_PB_MODE         0
`define RSA_PB_RUN          1
`define RSA_PB_STOP         2
`define RSA_ST_RUNNING      0
`define RSA_ST_LOCAL        1
`define RSA_ST_REM_RUN      2
`define RSA_ST_REM_STOP     3
`define RSA_ST_PB_RUN       4
`define RSA_ST_READY        5
`define RSA_ST_FAULT        6
`define RSA_ST_SMALL        7

// ****************************************************************
// Reset values and limits.
// ****************************************************************
`define RSA_SEL_RST         4'h0
`define RSA_SMALL_LAST_SEL  4'h7
`define RSA_RDATA_IDLE      8'h00

`endif

//--- design/rsa_pkg.sv
// ****************************************************************
// Types shared by the run/stop arbiter modules.
// ****************************************************************
package rsa_pkg;

    // Power-up self-check progress.
    typedef enum logic [2:0] {
        DIAG_CHECK = 3'b001,
        DIAG_READY = 3'b010,
        DIAG_FAULT = 3'b100
    } rsa_diag_e;

    // Remote control state set by the programming software.
    typedef enum logic [2:0] {
        REM_NONE = 3'b001,
        REM_RUN  = 3'b010,
        REM_STOP = 3'b100
    } rsa_remote_e;

    // State of the input synchroniser.
    typedef struct packed {
        logic [15:0] gp_meta;
        logic [15:0] gp_sync;
        logic        sw_meta;
        logic        sw_sync;
    } rsa_sync_s;

    // State of the arbiter core.
    typedef struct packed {
        rsa_diag_e   diag;
        rsa_remote_e remote;
        logic        term_en;
        logic [3:0]  term_sel;
        logic        small_unit;
        logic        pb_mode;
        logic        pb_run_flag;
        logic        pb_stop_flag;
        logic        pb_run;
        logic        local_q;
        logic        running;
        logic [7:0]  rdata;
    } rsa_state_s;

endpackage

//--- design/rsa_sync_if.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Synchronised local run sources, from synchroniser to core.
// ****************************************************************
interface rsa_sync_if;
    logic        sw_run;   // Panel switch in run position.
    logic [15:0] gp;       // General inputs, synchronised.

    modport src (output sw_run, output gp);
    modport dst (input sw_run, input gp);
endinterface // rsa_sync_if

`default_nettype wire

//--- design/rsa_input_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Two-stage synchroniser for the panel switch and general inputs.
// ****************************************************************
module rsa_input_sync (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Raw inputs.
    input  wire logic        sw_raw,
    input  wire logic [15:0] gp_raw,
    // Synchronised outputs.
    rsa_sync_if.src          sync
);

    rsa_pkg::rsa_sync_s q;        // Registered state.
    rsa_pkg::rsa_sync_s next_q;   // Next state.

    // The first stage feeds only the second, so metastability never
    // reaches the decision logic.
    always_comb begin
        next_q         = q;
        next_q.sw_meta = sw_raw;
        next_q.sw_sync = q.sw_meta;
        next_q.gp_meta = gp_raw;
        next_q.gp_sync = q.gp_meta;
    end

    // Synchronous reset clears both stages.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign sync.sw_run = q.sw_sync;
    assign sync.gp     = q.gp_sync;

    // Inputs appear two clocks after they are sampled. Only edges with two
    // reset-free edges behind them count, since reset flushes both stages.
    property p_sync_lag;
        @(posedge clk) disable iff (!reset_n)
        $past(reset_n) && $past(reset_n, 2)
            |-> (q.gp_sync == $past(gp_raw, 2)) && (q.sw_sync == $past(sw_raw, 2));
    endproperty
    a_sync_lag: assert property (p_sync_lag) else $error("sync lag wrong");

endmodule // rsa_input_sync

`default_nettype wire

//--- design/rsa_arbiter.sv
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rsa_defines.svh"


// ****************************************************************
// Run/stop arbiter core.
// ****************************************************************
module rsa_arbiter (
    // Clock and reset.
    input  wire logic        SYS_CLK,
    input  wire logic        RESET_N,
    // Local run sources and the unit size strap.
    input  wire logic        RUN_SWITCH,
    input  wire logic [15:0] GP_IN,
    input  wire logic        SMALL_UNIT,
    // Self-check result.
    input  wire logic        SELF_TEST_DONE,
    input  wire logic        SELF_TEST_OK,
    // Register port.
    input  wire logic [7:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    // Status outputs.
    output logic             RUN_OUT,
    output logic             RUN_LED,
    output logic             ERROR_LED
);

    // ****************************************************************
    // Helpers.
    // ****************************************************************

    // A selected terminal counts only if it exists on this unit size.
    function automatic logic term_valid(input logic en, input logic [3:0] sel,
                                        input logic is_small);
        term_valid = en && (!is_small || (sel <= `RSA_SMALL_LAST_SEL));
    endfunction

    // Combined local run request: switch OR valid terminal.
    function automatic logic local_request(input logic sw, input logic [15:0] gp,
                                           input logic en, input logic [3:0] sel,
                                           input logic is_small);
        local_request = sw || (term_valid(en, sel, is_small) && gp[sel]);
    endfunction

    // ****************************************************************
    // State and synchroniser.
    // ****************************************************************
    rsa_pkg::rsa_state_s q;          // Registered state.
    rsa_pkg::rsa_state_s next_q;     // Next state.
    rsa_sync_if          sync_bus(); // Synchronised inputs.
    logic                local_now;  // Local run request this cycle.
    logic                wr_rem_run; // Valid remote run write.
    logic                wr_rem_stop;// Valid remote stop write.

    rsa_input_sync u_sync (
        .clk     (SYS_CLK),
        .reset_n (RESET_N),
        .sw_raw  (RUN_SWITCH),
        .gp_raw  (GP_IN),
        .sync    (sync_bus.src)
    );

    // Local decision from synchronised sources.
    assign local_now = local_request(sync_bus.sw_run, sync_bus.gp, q.term_en,
                                     q.term_sel, q.small_unit);

    // A write with both command bits set is ambiguous and ignored.
    assign wr_rem_run  = WR && (ADDR == `RSA_ADDR_REMOTE) &&
                         WDATA[`RSA_REM_RUN] && !WDATA[`RSA_REM_STOP];
    assign wr_rem_stop = WR && (ADDR == `RSA_ADDR_REMOTE) &&
                         WDATA[`RSA_REM_STOP] && !WDATA[`RSA_REM_RUN];

    // ****************************************************************
    // Next-state logic.
    // ****************************************************************
    always_comb begin
        next_q         = q;
        next_q.local_q = local_now;
        next_q.rdata   = `RSA_RDATA_IDLE;

        // Self-check sequencing; the unit-size strap is caught while
        // the check runs, after reset has been released.
        case (q.diag)
            rsa_pkg::DIAG_CHECK: begin
                next_q.small_unit = SMALL_UNIT;
                if (SELF_TEST_DONE) begin
                    next_q.diag = SELF_TEST_OK ? rsa_pkg::DIAG_READY
                                               : rsa_pkg::DIAG_FAULT;
                end
            end
            rsa_pkg::DIAG_READY: begin
                next_q.diag = rsa_pkg::DIAG_READY;
            end
            rsa_pkg::DIAG_FAULT: begin
                next_q.diag = rsa_pkg::DIAG_FAULT;
            end
            default: begin
                next_q.diag = rsa_pkg::DIAG_CHECK;
            end
        endcase

        // Remote control; a new command wins over a local transition.
        case (q.remote)
            rsa_pkg::REM_NONE, rsa_pkg::REM_RUN: begin
                next_q.remote = q.remote;
            end
            rsa_pkg::REM_STOP: begin
                // Stop-to-run on a local source hands control back.
                if (local_now && !q.local_q) begin
                    next_q.remote = rsa_pkg::REM_NONE;
                end
            end
            default: begin
                next_q.remote = rsa_pkg::REM_NONE;
            end
        endcase
        if (wr_rem_stop) begin
            next_q.remote = rsa_pkg::REM_STOP;
        end else if (wr_rem_run) begin
            next_q.remote = rsa_pkg::REM_RUN;
        end

        // Register writes.
        if (WR && (ADDR == `RSA_ADDR_CTRL)) begin
            next_q.term_en  = WDATA[`RSA_CTRL_TERM_EN];
            next_q.term_sel = WDATA[`RSA_CTRL_SEL_MSB:`RSA_CTRL_SEL_LSB];
        end
        if (WR && (ADDR == `RSA_ADDR_PB)) begin
            next_q.pb_mode      = WDATA[`RSA_PB_MODE];
            next_q.pb_run_flag  = WDATA[`RSA_PB_RUN];
            next_q.pb_stop_flag = WDATA[`RSA_PB_STOP];
        end

        // Pushbutton latch: stop has priority over run.
        if (!q.pb_mode || q.pb_stop_flag) begin
            next_q.pb_run = 1'b0;
        end else if (q.pb_run_flag) begin
            next_q.pb_run = 1'b1;
        end

        // One decision per clock; nothing runs before the check passes.
        if (q.diag != rsa_pkg::DIAG_READY) begin
            next_q.running = 1'b0;
        end else if (q.remote == rsa_pkg::REM_RUN) begin
            next_q.running = 1'b1;
        end else if (q.remote == rsa_pkg::REM_STOP) begin
            next_q.running = 1'b0;
        end else begin
            next_q.running = local_now || q.pb_run;
        end

        // Register reads; unmapped offsets read as zero.
        if (RD) begin
            case (ADDR)
                `RSA_ADDR_CTRL: begin
                    next_q.rdata = {q.term_sel, 3'h0, q.term_en};
                end
                `RSA_ADDR_PB: begin
                    next_q.rdata = {5'h00, q.pb_stop_flag, q.pb_run_flag, q.pb_mode};
                end
                `RSA_ADDR_STATUS: begin
                    next_q.rdata[`RSA_ST_RUNNING]  = q.running;
                    next_q.rdata[`RSA_ST_LOCAL]    = q.local_q;
                    next_q.rdata[`RSA_ST_REM_RUN]  = (q.remote == rsa_pkg::REM_RUN);
                    next_q.rdata[`RSA_ST_REM_STOP] = (q.remote == rsa_pkg::REM_STOP);
                    next_q.rdata[`RSA_ST_PB_RUN]   = q.pb_run;
                    next_q.rdata[`RSA_ST_READY]    = (q.diag == rsa_pkg::DIAG_READY);
                    next_q.rdata[`RSA_ST_FAULT]    = (q.diag == rsa_pkg::DIAG_FAULT);
                    next_q.rdata[`RSA_ST_SMALL]    = q.small_unit;
                end
                default: begin
                    next_q.rdata = `RSA_RDATA_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // State register. Reset is power-up: remote control is forgotten.
    // ****************************************************************
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            q.diag         <= rsa_pkg::DIAG_CHECK;
            q.remote       <= rsa_pkg::REM_NONE;
            q.term_en      <= 1'b0;
            q.term_sel     <= `RSA_SEL_RST;
            q.small_unit   <= 1'b0;
            q.pb_mode      <= 1'b0;
            q.pb_run_flag  <= 1'b0;
            q.pb_stop_flag <= 1'b0;
            q.pb_run       <= 1'b0;
            q.local_q      <= 1'b0;
            q.running      <= 1'b0;
            q.rdata        <= `RSA_RDATA_IDLE;
        end else begin
            q <= next_q;
        end
    end

    // Outputs from flip-flops; ERROR_LED is decoded from the diag state.
    assign RDATA     = q.rdata;
    assign RUN_OUT   = q.running;
    assign RUN_LED   = q.running;
    assign ERROR_LED = (q.diag == rsa_pkg::DIAG_FAULT);

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    property p_switch_run;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (q.diag == rsa_pkg::DIAG_READY) && (q.remote == rsa_pkg::REM_NONE)
            && sync_bus.sw_run |=> RUN_OUT;
    endproperty
    a_switch_run: assert property (p_switch_run) else $error("switch run lost");

    property p_local_stop;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (q.remote == rsa_pkg::REM_NONE) && !local_now && !q.pb_run |=> !RUN_OUT;
    endproperty
    a_local_stop: assert property (p_local_stop) else $error("stop ignored");

    property p_term_run;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (q.diag == rsa_pkg::DIAG_READY) && (q.remote == rsa_pkg::REM_NONE)
            && term_valid(q.term_en, q.term_sel, q.small_unit)
            && sync_bus.gp[q.term_sel] |=> RUN_OUT;
    endproperty
    a_term_run: assert property (p_term_run) else $error("terminal run lost");

    property p_small_range;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        q.small_unit && (q.term_sel > `RSA_SMALL_LAST_SEL) && (q.remote == rsa_pkg::REM_NONE)
            && !sync_bus.sw_run && !q.pb_run |=> !RUN_OUT;
    endproperty
    a_small_range: assert property (p_small_range) else $error("bad terminal");

    property p_remote_stop;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        wr_rem_stop |=> ##1 !RUN_OUT;
    endproperty
    a_remote_stop: assert property (p_remote_stop) else $error("remote stop");

    property p_remote_run;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        wr_rem_run && (q.diag == rsa_pkg::DIAG_READY) |=> ##1 RUN_OUT;
    endproperty
    a_remote_run: assert property (p_remote_run) else $error("remote run");

    property p_local_resume;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (q.remote == rsa_pkg::REM_STOP) && local_now && !q.local_q && !WR
            |=> (q.remote == rsa_pkg::REM_NONE);
    endproperty
    a_local_resume: assert property (p_local_resume) else $error("no resume");

    property p_pb_stop;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        q.pb_mode && q.pb_stop_flag && (q.remote == rsa_pkg::REM_NONE)
            && !local_now && !WR |=> !q.pb_run ##1 (!RUN_OUT || $past(local_now));
    endproperty
    a_pb_stop: assert property (p_pb_stop) else $error("pushbutton stop");

    property p_fault;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (q.diag == rsa_pkg::DIAG_FAULT) |-> !RUN_OUT && ERROR_LED && !RUN_LED;
    endproperty
    a_fault: assert property (p_fault) else $error("fault ran");

    property p_check_hold;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (q.diag == rsa_pkg::DIAG_CHECK) |=> !RUN_OUT;
    endproperty
    a_check_hold: assert property (p_check_hold) else $error("ran unchecked");

endmodule // rsa_arbiter

`default_nettype wire

//--- bench/rsa_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Operator panel, field inputs and programming host.
// ****************************************************************
module rsa_host_model (
    // Clock.
    input  wire logic        clk,
    // Operator panel and field inputs.
    output logic             run_switch,
    output logic [15:0]      gp_in,
    output logic             small_unit,
    // Self-check result.
    output logic             self_test_done,
    output logic             self_test_ok,
    // Register port, host side.
    output logic [7:0]       addr,
    output logic [7:0]       wdata,
    output logic             wr,
    output logic             rd,
    input  wire logic [7:0]  rdata
);

    // The panel comes up at stop, so the controller starts halted.
    initial begin
        run_switch     = 1'b0;
        gp_in          = 16'h0000;
        small_unit     = 1'b0;
        self_test_done = 1'b0;
        self_test_ok   = 1'b0;
        addr           = 8'h00;
        wdata          = 8'h00;
        wr             = 1'b0;
        rd             = 1'b0;
    end

    // Moves the panel switch and the field inputs after an edge.
    // Callers keep the switch at stop while the terminal drives the run; the first remote commands find it at run.
    task automatic set_local(input logic sw, input logic [15:0] gp);
        @(posedge clk);
        run_switch <= sw;
        gp_in      <= gp;
    endtask

    // Presents a self-check result and the unit size strap.
    task automatic set_check(input logic done, input logic ok, input logic is_small);
        @(posedge clk);
        self_test_done <= done;
        self_test_ok   <= ok;
        small_unit     <= is_small;
    endtask

    // One-cycle write; idle lines then carry the inverse so that no
    // stale address or data can pass for a live one.
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        addr  <= ~a;
        wdata <= ~d;
    endtask

    // One-cycle read; data are taken in the cycle after the strobe only.
    task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask

endmodule // rsa_host_model

`default_nettype wire

//--- bench/rsa_arbiter_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsa_defines.svh"

// One comparison: counts it and reports a mismatch at once.
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end

// ****************************************************************
// Run/stop arbiter testbench.
// ****************************************************************
module rsa_arbiter_bench;

    logic        SYS_CLK;      // Scan clock, 100 ns period.
    logic        RESET_N;      // Synchronous reset, active low.
    logic        RUN_SWITCH;   // Panel switch from the host model.
    logic [15:0] GP_IN;        // General inputs from the host model.
    logic        SMALL_UNIT;   // Unit size strap.
    logic        ST_DONE;      // Self-check finished.
    logic        ST_OK;        // Self-check passed.
    logic [7:0]  ADDR;         // Register address.
    logic [7:0]  WDATA;        // Register write data.
    logic        WR;           // Write strobe.
    logic        RD;           // Read strobe.
    logic [7:0]  RDATA;        // Register read data.
    logic        RUN_OUT;      // Running state.
    logic        RUN_LED;      // Run indicator.
    logic        ERROR_LED;    // Fault indicator.
    int          fails;        // Mismatches seen.
    int          total_checks; // Comparisons made.
    int          n;            // Edges counted by the last wait.
    logic [7:0]  rv;           // Last read value.

    // Clock generator.
    initial SYS_CLK = 1'b0;
    always #50 SYS_CLK = ~SYS_CLK;

    rsa_arbiter uut (
        .SYS_CLK        (SYS_CLK),
        .RESET_N        (RESET_N),
        .RUN_SWITCH     (RUN_SWITCH),
        .GP_IN          (GP_IN),
        .SMALL_UNIT     (SMALL_UNIT),
        .SELF_TEST_DONE (ST_DONE),
        .SELF_TEST_OK   (ST_OK),
        .ADDR           (ADDR),
        .WDATA          (WDATA),
        .WR             (WR),
        .RD             (RD),
        .RDATA          (RDATA),
        .RUN_OUT        (RUN_OUT),
        .RUN_LED        (RUN_LED),
        .ERROR_LED      (ERROR_LED)
    );

    rsa_host_model host (
        .clk            (SYS_CLK),
        .run_switch     (RUN_SWITCH),
        .gp_in          (GP_IN),
        .small_unit     (SMALL_UNIT),
        .self_test_done (ST_DONE),
        .self_test_ok   (ST_OK),
        .addr           (ADDR),
        .wdata          (WDATA),
        .wr             (WR),
        .rd             (RD),
        .rdata          (RDATA)
    );

    // ****************************************************************
    // Helpers.
    // ****************************************************************

    // Prints the verdict and ends the run.
    task automatic close_out();
        if (fails == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Waits, bounded, for the running state; returns the edges taken.
    task automatic wait_run(input logic exp, output int cnt);
        cnt = 0;
        while (cnt < 20) begin
            @(posedge SYS_CLK);
            #1;
            cnt++;
            if (RUN_OUT === exp) break;
        end
        total_checks++;
        if (RUN_OUT !== exp) begin
            fails++;
            $display("unexpected run_out expected %h seen %h", exp, RUN_OUT);
            close_out();
        end
    endtask

    // Power cycle: reset with the check pending, then report the result.
    task automatic power_cycle(input logic is_small, input logic ok);
        @(posedge SYS_CLK);
        RESET_N <= 1'b0;
        host.set_check(1'b0, 1'b0, is_small);
        repeat (3) @(posedge SYS_CLK);
        RESET_N <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        host.set_check(1'b1, ok, is_small);
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        RESET_N      = 1'b0;
        fails        = 0;
        total_checks = 0;
        repeat (2) @(posedge SYS_CLK);
        RESET_N <= 1'b1;
        // Reset values and an unmapped address, before the check ends.
        host.bus_read(`RSA_ADDR_CTRL, rv);
        `CHK("ctrl reset", 8'h00, rv)
        host.bus_read(8'h10, rv);
        `CHK("unmapped read", 8'h00, rv)
        host.set_local(1'b1, 16'h0000);
        repeat (6) @(posedge SYS_CLK);
        #1;
        `CHK("run before check", 1'b0, RUN_OUT)
        host.set_check(1'b1, 1'b1, 1'b0);
        wait_run(1'b1, n);
        `CHK("run led", 1'b1, RUN_LED)
        `CHK("error led off", 1'b0, ERROR_LED)
        host.bus_read(`RSA_ADDR_STATUS, rv);
        `CHK("status running", 8'h23, rv)
        // Switch to stop; pin to output takes two sync edges and one decision.
        host.set_local(1'b0, 16'h0000);
        wait_run(1'b0, n);
        `CHK("decision latency", 3, n)
        // Every terminal select, with all other inputs set against it.
        host.bus_write(`RSA_ADDR_CTRL, 8'hf1);
        host.bus_read(`RSA_ADDR_CTRL, rv);
        `CHK("ctrl readback", 8'hf1, rv)
        for (int s = 0; s < 16; s++) begin
            host.set_local(1'b0, ~(16'h0001 << s));
            host.bus_write(`RSA_ADDR_CTRL, {s[3:0], 4'h1});
            wait_run(1'b0, n);
            host.set_local(1'b0, 16'h0001 << s);
            wait_run(1'b1, n);
        end
        // Terminal off: the switch alone decides.
        host.set_local(1'b1, 16'h0000);
        repeat (6) @(posedge SYS_CLK);
        #1;
        `CHK("switch or terminal", 1'b1, RUN_OUT)
        host.bus_write(`RSA_ADDR_CTRL, 8'h00);
        // Remote stop, remote run, then a local stop-to-run resume.
        host.bus_write(`RSA_ADDR_REMOTE, 8'h02);
        wait_run(1'b0, n);
        host.bus_read(`RSA_ADDR_STATUS, rv);
        `CHK("status remote stop", 8'h2a, rv)
        host.bus_write(`RSA_ADDR_REMOTE, 8'h01);
        wait_run(1'b1, n);
        host.bus_write(`RSA_ADDR_REMOTE, 8'h02);
        wait_run(1'b0, n);
        host.set_local(1'b0, 16'h0000);
        repeat (5) @(posedge SYS_CLK);
        host.set_local(1'b1, 16'h0000);
        wait_run(1'b1, n);
        host.bus_read(`RSA_ADDR_STATUS, rv);
        `CHK("status resumed", 8'h23, rv)
        // A write with both command bits is refused.
        host.set_local(1'b0, 16'h0000);
        wait_run(1'b0, n);
        host.bus_write(`RSA_ADDR_REMOTE, 8'h03);
        host.bus_read(`RSA_ADDR_STATUS, rv);
        `CHK("both bits ignored", 8'h20, rv)
        host.bus_read(`RSA_ADDR_REMOTE, rv);
        `CHK("remote reads zero", 8'h00, rv)
        host.bus_write(`RSA_ADDR_REMOTE, 8'h01);
        wait_run(1'b1, n);
        // Power cycle on a small unit: remote run is forgotten.
        power_cycle(1'b1, 1'b1);
        repeat (6) @(posedge SYS_CLK);
        #1;
        `CHK("remote cleared", 1'b0, RUN_OUT)
        host.bus_read(`RSA_ADDR_STATUS, rv);
        `CHK("status small", 8'ha0, rv)
        host.bus_write(`RSA_ADDR_CTRL, 8'h81);
        host.set_local(1'b0, 16'h0100);
        repeat (6) @(posedge SYS_CLK);
        #1;
        `CHK("select above 7", 1'b0, RUN_OUT)
        host.bus_write(`RSA_ADDR_CTRL, 8'h71);
        host.set_local(1'b0, 16'h0080);
        wait_run(1'b1, n);
        host.set_local(1'b0, 16'h0000);
        host.bus_write(`RSA_ADDR_CTRL, 8'h00);
        wait_run(1'b0, n);
        // Pushbuttons: run latches, stop flag and mode off both clear.
        host.bus_write(`RSA_ADDR_PB, 8'h01);
        host.bus_write(`RSA_ADDR_PB, 8'h03);
        wait_run(1'b1, n);
        host.bus_write(`RSA_ADDR_PB, 8'h01);
        repeat (4) @(posedge SYS_CLK);
        #1;
        `CHK("pushbutton latched", 1'b1, RUN_OUT)
        host.bus_write(`RSA_ADDR_PB, 8'h07);
        host.bus_read(`RSA_ADDR_PB, rv);
        `CHK("pb readback", 8'h07, rv)
        wait_run(1'b0, n);
        host.bus_write(`RSA_ADDR_PB, 8'h03);
        wait_run(1'b1, n);
        host.bus_write(`RSA_ADDR_PB, 8'h00);
        wait_run(1'b0, n);
        // Failed self-check: fault lit, never running.
        host.set_local(1'b1, 16'h0000);
        power_cycle(1'b0, 1'b0);
        repeat (6) @(posedge SYS_CLK);
        #1;
        `CHK("error led", 1'b1, ERROR_LED)
        `CHK("no run on fault", 1'b0, RUN_OUT)
        host.bus_read(`RSA_ADDR_STATUS, rv);
        `CHK("fault flag", 1'b1, rv[`RSA_ST_FAULT])
        close_out();
    end

endmodule // rsa_arbiter_bench

`default_nettype wire
